/* src/lsdt_line_state_duration_timer.sv */
// line-state duration timer with noise timer snapshots on the control bus
`timescale 1ns/1ps
`default_nettype none
`include "lsdt_map.svh"

// Overview of operation
// - reading noise count snapshot returns noise timer as it is at that read
// - writes to snapshot registers change nothing and pulse write rejected flag
// - noise count snapshot holds count in bits 0-6, change seen in bit 7
// - reading noise prescale snapshot returns all 8 prescaler bits at that read
// - state timer decrements each 100 ns step when prescaler zero and state qualifies
// - from load, timer reaches zero after (pthr+1)*thr+pthr steps
// - both zero in qualifying state reloads timer and prescaler together
// - change into a qualifying state reloads timer and prescaler
// - writing either duration threshold register reloads both counters
// - prescaler reloads from its threshold whenever it reaches zero
// - active, noise or unknown line state holds the state timer
// - prescaler is a down counter stepping every 100 ns in qualifying state
// - duration threshold holds 7 bits, bit 7 reads zero and ignores writes
// - duration prescale threshold holds 8 bits, always read and write
// - duration count snapshot returns count in bits 0-6, change seen in bit 7
// - noise timer decrements once per prescaler period during noise states
// - change into noise, active or unknown keeps noise counting, no reload
module lsdt_line_state_duration_timer (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // line state from the detector
   input  wire lsdt_pkg::lsdt_ls_e   line_state,
   // noise timer start values and their reload strobe
   input  wire logic [6:0]           noise_threshold,
   input  wire logic [7:0]           noise_prescale_threshold,
   input  wire logic                 noise_thr_written,
   // control bus
   input  wire lsdt_pkg::lsdt_cb_req_s cb_req,
   output lsdt_pkg::lsdt_cb_rsp_s    cb_rsp,
   // one-cycle pulse that sets the write rejected bit of the interrupt condition reg
   output logic                      write_rejected_flag
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [6:0]         dthr;
      logic [7:0]         dpthr;
      lsdt_pkg::lsdt_ls_e prev_ls;
      logic [1:0]         step_cnt;
      logic               dchg;
      logic               nchg;
      lsdt_pkg::lsdt_cb_rsp_s rsp;
      logic               rej;
   } lsdt_top_s;

   lsdt_top_s st;
   lsdt_top_s next_st;

   logic [6:0] dcount;
   logic [7:0] dpcount;
   logic [6:0] ncount;
   logic [7:0] npcount;
   logic       step;
   logic       qual_ls;
   logic       noise_ls;
   logic       ls_change;
   logic       thr_write;
   logic       dload;
   logic       nload;

   // ----------------------------------------------------------------------
   // line state classes and load conditions
   // ----------------------------------------------------------------------
   always_comb begin
      unique case (line_state)
         lsdt_pkg::LS_IDLE, lsdt_pkg::LS_HALT, lsdt_pkg::LS_MASTER,
         lsdt_pkg::LS_QUIET, lsdt_pkg::LS_NO_SIGNAL: qual_ls = 1'b1;
         lsdt_pkg::LS_ACTIVE, lsdt_pkg::LS_NOISE,
         lsdt_pkg::LS_UNKNOWN:                       qual_ls = 1'b0;
      endcase
   end

   assign noise_ls  = !qual_ls;
   assign ls_change = (line_state != st.prev_ls);
   // 80 ns does not divide the 50 ns clock; the step rounds up to whole cycles
   assign step      = (st.step_cnt == 2'(`LSDT_STEP_CYC - 1));
   // a read with a write in the same cycle is taken as a read only, so it must not reload
   assign thr_write = cb_req.wr && !cb_req.rd &&
                      (cb_req.addr == `LSDT_OFS_DURATION_THRESHOLD ||
                       cb_req.addr == `LSDT_OFS_DURATION_PRESCALE_THR);
   assign dload     = thr_write || (ls_change && qual_ls);
   // noise counters are held in reload while a quiet-class state lasts or noise_thr_written is high
   assign nload     = noise_thr_written || qual_ls;

   // ----------------------------------------------------------------------
   // the two prescaled timers
   // ----------------------------------------------------------------------
   lsdt_prescaled_timer u_duration (
      .clk      (clk),
      .reset_n  (reset_n),
      .step     (step),
      .count_en (qual_ls),
      .load     (dload),
      // the write edge loads the value being written, not the one it replaces
      .thr      (next_st.dthr),
      .pthr     (next_st.dpthr),
      .count    (dcount),
      .pcount   (dpcount)
   );

   lsdt_prescaled_timer u_noise (
      .clk      (clk),
      .reset_n  (reset_n),
      .step     (step),
      .count_en (noise_ls),
      .load     (nload),
      .thr      (noise_threshold),
      .pthr     (noise_prescale_threshold),
      .count    (ncount),
      .pcount   (npcount)
   );

   // ----------------------------------------------------------------------
   // register file and next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.prev_ls  = line_state;
      next_st.step_cnt = step ? 2'h0 : st.step_cnt + 2'h1;
      next_st.rsp      = '0;
      next_st.rej      = 1'b0;

      if (cb_req.rd) begin
         unique case (cb_req.addr)
            `LSDT_OFS_NOISE_COUNT_SNAPSHOT: begin
               next_st.rsp.ack   = 1'b1;
               next_st.rsp.rdata = {st.nchg, ncount};
               next_st.nchg      = 1'b0;
            end
            `LSDT_OFS_NOISE_PRESCALE_SNAPSHOT: begin
               next_st.rsp.ack   = 1'b1;
               next_st.rsp.rdata = npcount;
            end
            `LSDT_OFS_DURATION_THRESHOLD: begin
               next_st.rsp.ack   = 1'b1;
               next_st.rsp.rdata = {1'b0, st.dthr};
            end
            `LSDT_OFS_DURATION_PRESCALE_THR: begin
               next_st.rsp.ack   = 1'b1;
               next_st.rsp.rdata = st.dpthr;
            end
            `LSDT_OFS_DURATION_COUNT_SNAPSHOT: begin
               next_st.rsp.ack   = 1'b1;
               next_st.rsp.rdata = {st.dchg, dcount};
               next_st.dchg      = 1'b0;
            end
            default: begin
               // other offsets belong to other blocks; stay silent
               next_st.rsp = '0;
            end
         endcase
      end else if (cb_req.wr) begin
         unique case (cb_req.addr)
            `LSDT_OFS_DURATION_THRESHOLD: begin
               next_st.rsp.ack = 1'b1;
               next_st.dthr    = cb_req.wdata[`LSDT_COUNT_MSB:0];
            end
            `LSDT_OFS_DURATION_PRESCALE_THR: begin
               next_st.rsp.ack = 1'b1;
               next_st.dpthr   = cb_req.wdata;
            end
            `LSDT_OFS_NOISE_COUNT_SNAPSHOT, `LSDT_OFS_NOISE_PRESCALE_SNAPSHOT,
            `LSDT_OFS_DURATION_COUNT_SNAPSHOT: begin
               next_st.rsp.ack = 1'b1;
               next_st.rej     = 1'b1;
            end
            default: begin
               next_st.rsp = '0;
            end
         endcase
      end

      // a change in the same cycle as the clearing read wins
      if (ls_change) begin
         next_st.dchg = 1'b1;
         next_st.nchg = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st          <= '0;
         st.dthr     <= `LSDT_RST_THRESHOLD;
         st.dpthr    <= `LSDT_RST_PRESCALE_THR;
         st.prev_ls  <= lsdt_pkg::LS_ACTIVE;
      end else begin
         st <= next_st;
      end
   end

   assign cb_rsp              = st.rsp;
   assign write_rejected_flag = st.rej;

endmodule // lsdt_line_state_duration_timer

`default_nettype wire

/* shared/lsdt_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LSDT_MAP_SVH
`define LSDT_MAP_SVH

// ----------------------------------------------------------------------
// register offsets on the control bus
// ----------------------------------------------------------------------
`define LSDT_OFS_NOISE_COUNT_SNAPSHOT     8'h0f
`define LSDT_OFS_NOISE_PRESCALE_SNAPSHOT  8'h10
`define LSDT_OFS_DURATION_THRESHOLD       8'h11
`define LSDT_OFS_DURATION_PRESCALE_THR    8'h12
`define LSDT_OFS_DURATION_COUNT_SNAPSHOT  8'h13

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LSDT_COUNT_MSB         6
`define LSDT_CHANGE_BIT        7
`define LSDT_PRESCALE_MSB      7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LSDT_RST_THRESHOLD     7'h00
`define LSDT_RST_PRESCALE_THR  8'h00

// ----------------------------------------------------------------------
// timing: one counting step, rounded up to whole clock cycles
// ----------------------------------------------------------------------
`define LSDT_STEP_NS           80
`define LSDT_CLK_NS            50
`define LSDT_STEP_CYC          ((`LSDT_STEP_NS + `LSDT_CLK_NS - 1) / `LSDT_CLK_NS)

`endif

/* shared/lsdt_pkg.sv */
// types shared by the line-state duration timer files
package lsdt_pkg;

   // received line state as reported by the line-state detector
   typedef enum logic [2:0] {
      LS_ACTIVE,
      LS_IDLE,
      LS_HALT,
      LS_MASTER,
      LS_QUIET,
      LS_NOISE,
      LS_UNKNOWN,
      LS_NO_SIGNAL
   } lsdt_ls_e;

   // control bus request, one cycle per access
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lsdt_cb_req_s;

   // control bus answer
   typedef struct packed {
      logic       ack;
      logic [7:0] rdata;
   } lsdt_cb_rsp_s;

endpackage : lsdt_pkg

/* src/lsdt_prescaled_timer.sv */
// prescaled down timer: 7-bit main count driven by an 8-bit prescaler
`timescale 1ns/1ps
`default_nettype none

module lsdt_prescaled_timer (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // control
   input  wire logic       step,
   input  wire logic       count_en,
   input  wire logic       load,
   // start values
   input  wire logic [6:0] thr,
   input  wire logic [7:0] pthr,
   // counts
   output logic      [6:0] count,
   output logic      [7:0] pcount
);

   typedef struct packed {
      logic [6:0] cnt;
      logic [7:0] pcnt;
   } lsdt_tmr_s;

   lsdt_tmr_s st;
   lsdt_tmr_s next_st;

   always_comb begin
      next_st = st;
      if (load) begin
         next_st.cnt  = thr;
         next_st.pcnt = pthr;
      end else if (step && count_en) begin
         if (st.cnt == 7'h00 && st.pcnt == 8'h00) begin
            // both expired: restart the whole period
            next_st.cnt  = thr;
            next_st.pcnt = pthr;
         end else if (st.pcnt == 8'h00) begin
            next_st.pcnt = pthr;
            next_st.cnt  = st.cnt - 7'h01;
         end else begin
            next_st.pcnt = st.pcnt - 8'h01;
         end
      end
   end

   // (pthr+1)*thr + pthr steps from load to zero falls out of this order
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count  = st.cnt;
   assign pcount = st.pcnt;

endmodule // lsdt_prescaled_timer

`default_nettype wire

/* testbench/lsdt_props.sv */
// control bus assertions for the line-state duration timer
`timescale 1ns/1ps
`default_nettype none
module lsdt_props (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   reset_n,
   // watched inputs
   input wire lsdt_pkg::lsdt_ls_e     line_state,
   input wire logic [6:0]             noise_threshold,
   input wire logic [7:0]             noise_prescale_threshold,
   input wire logic                   noise_thr_written,
   input wire lsdt_pkg::lsdt_cb_req_s cb_req,
   // watched outputs
   input wire lsdt_pkg::lsdt_cb_rsp_s cb_rsp,
   input wire logic                   write_rejected_flag
);
   // ------------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------------
   logic               rd, wr, snap, rd13, pend, bit_exp, q_prev;
   lsdt_pkg::lsdt_ls_e prev_ls;
   assign rd      = cb_req.rd;
   assign wr      = cb_req.wr & ~cb_req.rd;
   assign snap    = cb_req.addr inside {8'h0f, 8'h10, 8'h13};
   assign rd13    = rd && cb_req.addr == 8'h13;
   // set wins over the clearing read
   assign bit_exp = (pend & ~rd13) | (line_state != prev_ls);
   assign q_prev  = !(prev_ls inside {lsdt_pkg::LS_ACTIVE, lsdt_pkg::LS_NOISE,
                                      lsdt_pkg::LS_UNKNOWN});
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_ls <= lsdt_pkg::LS_ACTIVE;
         pend    <= 1'b0;
      end else begin
         prev_ls <= line_state;
         pend    <= bit_exp;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   a_reject_flag_set: assert property (wr && snap |=> write_rejected_flag && cb_rsp.ack)
      else $error("snapshot write gave no reject pulse");
   a_flag_only_reject: assert property (!(wr && snap) |=> !write_rejected_flag)
      else $error("reject pulse without snapshot write");
   a_snap_read_ack: assert property (rd && snap |=> cb_rsp.ack)
      else $error("snapshot read not answered");
   a_thr_readback: assert property ((wr && cb_req.addr == 8'h11) ##1 !cb_req.wr
      ##1 (rd && cb_req.addr == 8'h11) |=> cb_rsp.rdata == {1'b0, $past(cb_req.wdata[6:0], 3)})
      else $error("threshold readback wrong");
   a_pthr_readback: assert property ((wr && cb_req.addr == 8'h12) ##1 !cb_req.wr
      ##1 (rd && cb_req.addr == 8'h12) |=> cb_rsp.rdata == $past(cb_req.wdata, 3))
      else $error("prescale threshold readback wrong");
   a_noise_cnt_snap: assert property (rd && cb_req.addr == 8'h0f && q_prev &&
      $stable(noise_threshold) |=> cb_rsp.rdata[6:0] == $past(noise_threshold))
      else $error("noise count snapshot wrong");
   a_noise_pre_snap: assert property (rd && cb_req.addr == 8'h10 && q_prev &&
      $stable(noise_prescale_threshold) |=> cb_rsp.rdata == $past(noise_prescale_threshold))
      else $error("noise prescale snapshot wrong");
   a_dur_change_bit: assert property (rd13 |=> cb_rsp.rdata[7] == $past(pend))
      else $error("duration change bit wrong");
endmodule // lsdt_props
bind lsdt_line_state_duration_timer lsdt_props u_props (
   .clk(clk), .reset_n(reset_n), .line_state(line_state), .noise_threshold(noise_threshold),
   .noise_prescale_threshold(noise_prescale_threshold), .noise_thr_written(noise_thr_written),
   .cb_req(cb_req), .cb_rsp(cb_rsp), .write_rejected_flag(write_rejected_flag));
`default_nettype wire

/* testbench/lsdt_host_model.sv */
// control bus master standing in for the management processor
`timescale 1ns/1ps
`default_nettype none
module lsdt_host_model (
   // clock
   input  wire logic                  clk,
   // control bus request
   output var lsdt_pkg::lsdt_cb_req_s cb_req
);
   initial cb_req = '0;
   // request stands one cycle, then a quiet cycle, so back-to-back calls
   // never drive the strobe twice in one time step
   task automatic xfer(input logic is_rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cb_req <= '{rd: is_rd, wr: !is_rd, addr: a, wdata: d};
      @(posedge clk);
      cb_req <= '0;
   endtask
endmodule // lsdt_host_model
`default_nettype wire

/* testbench/line_state_duration_timer_tb.sv */
// self-checking bench for the line-state duration timer
`timescale 1ns/1ps
`default_nettype none
module line_state_duration_timer_tb;
   logic                   clk = 1'b0;
   logic                   reset_n = 1'b0;
   lsdt_pkg::lsdt_ls_e     line_state = lsdt_pkg::LS_ACTIVE;
   logic [6:0]             nthr = 7'h00;
   logic [6:0]             nt;
   logic [7:0]             pv;
   logic                   nthr_wr = 1'b0;
   lsdt_pkg::lsdt_cb_req_s cb_req;
   lsdt_pkg::lsdt_cb_rsp_s cb_rsp;
   logic                   wr_rej;
   logic [8:0]             exp_q[$];
   logic [7:0]             snap_a[3] = '{8'h0f, 8'h10, 8'h13};
   int                     error_cnt = 0;
   int                     num_checks = 0;
   always #25 clk = ~clk;
   lsdt_line_state_duration_timer dut (.clk(clk), .reset_n(reset_n), .line_state(line_state),
      .noise_threshold(nthr), .noise_prescale_threshold(8'hff), .noise_thr_written(nthr_wr),
      .cb_req(cb_req), .cb_rsp(cb_rsp), .write_rejected_flag(wr_rej));
   lsdt_host_model host (.clk(clk), .cb_req(cb_req));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // note the answer before the request so the monitor finds it at the ack
   task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d,
                      input logic [8:0] e);
      exp_q.push_back(e);
      host.xfer(r, a, d);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // an ack with nothing noted meets an unknown and so always mismatches
   always @(posedge clk) begin
      if (reset_n && cb_rsp.ack !== 1'b0)
         chk({wr_rej, cb_rsp.rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx);
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(44960));
      nt = 7'(2 + $urandom_range(125));
      pv = 8'($urandom);
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      nthr <= nt;
      @(posedge clk);
      nthr_wr <= 1'b1;
      @(posedge clk);
      nthr_wr <= 1'b0;
      acc(1'h1, 8'h0f, 8'h00, {2'h0, nt});
      acc(1'h0, 8'h11, 8'hff, 9'h000);
      acc(1'h1, 8'h11, 8'h00, 9'h07f);
      acc(1'h0, 8'h12, pv, 9'h000);
      acc(1'h1, 8'h12, 8'h00, {1'h0, pv});
      acc(1'h1, 8'h13, 8'h00, 9'h07f);
      foreach (snap_a[i]) acc(1'h0, snap_a[i], 8'h55, 9'h100);
      acc(1'h1, 8'h13, 8'h00, 9'h07f);
      host.xfer(1'h1, 8'h20, 8'h00);
      acc(1'h0, 8'h11, 8'h03, 9'h000);
      acc(1'h1, 8'h13, 8'h00, 9'h003);
      acc(1'h0, 8'h12, 8'hff, 9'h000);
      // slow prescaler: one count per 256 steps keeps the read points wide
      @(posedge clk);
      line_state <= lsdt_pkg::LS_IDLE;
      acc(1'h1, 8'h0f, 8'h00, {2'h1, nt});
      acc(1'h1, 8'h10, 8'h00, 9'h0ff);
      acc(1'h1, 8'h13, 8'h00, 9'h083);
      acc(1'h1, 8'h13, 8'h00, 9'h003);
      repeat (700) @(posedge clk);
      line_state <= lsdt_pkg::LS_NOISE;
      repeat (700) @(posedge clk);
      acc(1'h1, 8'h13, 8'h00, 9'h082);
      acc(1'h1, 8'h0f, 8'h00, {2'h1, nt - 7'h1});
      @(posedge clk);
      line_state <= lsdt_pkg::LS_IDLE;
      acc(1'h1, 8'h13, 8'h00, 9'h083);
      repeat (1790) @(posedge clk);
      acc(1'h1, 8'h13, 8'h00, 9'h000);
      repeat (500) @(posedge clk);
      acc(1'h1, 8'h13, 8'h00, 9'h003);
      repeat (5) @(posedge clk);
      chk(9'(exp_q.size()), 9'h000);
      summarize();
   end
endmodule // line_state_duration_timer_tb
`default_nettype wire
